// >>> common/efp_pkg.sv
/*
 * Types of the external-host flash programming controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package efp_pkg;

  typedef enum logic [3:0] {
    CMD_READ_ID,
    CMD_CHIP_ERASE,
    CMD_BLOCK_ERASE,
    CMD_SECTOR_ERASE,
    CMD_BYTE_PROGRAM,
    CMD_PROGRAM_SECURITY_BIT_THREE,
    CMD_PROGRAM_SECURITY_BIT_TWO,
    CMD_PROGRAM_SECURITY_BIT_ONE,
    CMD_PROGRAM_CONFIG_BIT_ONE,
    CMD_PROGRAM_CONFIG_BIT_ZERO,
    CMD_BURST_PROGRAM,
    CMD_BYTE_VERIFY
  } efp_cmd_e;

  typedef enum logic [2:0] {
    ARR_IDLE,
    ARR_READ,
    ARR_PROG,
    ARR_ERASE_SECTOR,
    ARR_ERASE_BLOCK,
    ARR_ERASE_CHIP
  } efp_arr_op_e;

  typedef enum logic [1:0] {
    BLK_PRIMARY,
    BLK_SECONDARY,
    BLK_NONE
  } efp_blk_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_CHECK,
    ST_WAIT,
    ST_BURST
  } efp_state_e;

  typedef struct packed {
    efp_cmd_e    cmd;
    logic [15:0] addr;
  } efp_cmd_s;

  typedef struct packed {
    efp_arr_op_e op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } efp_arr_s;

  typedef struct packed {
    efp_state_e  st;
    efp_cmd_s    cmd;
    efp_arr_s    arr;
    logic [21:0] timer;
    logic [7:0]  idx;
    logic        first;
    logic        busy;
    logic        done;
    logic        refused;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        dready;
    logic [2:0]  sec;
    logic [1:0]  cfg;
  } efp_state_s;

endpackage : efp_pkg

// >>> common/efp_regs.svh
/*
 * Constants of the external-host flash programming controller: field
 * positions, reset values and operation times.
 * Assumes a 200 MHz controller clock; times are kept in their own units.
 */
`ifndef EFP_REGS_SVH
`define EFP_REGS_SVH

// Clock period in ns
`define EFP_CLK_NS        5.0
// Operation times
`define EFP_T_CE_MS       11.7
`define EFP_T_BE_MS       9.4
`define EFP_T_SE_MIN_MS   1.1
`define EFP_T_PB_US       110.0
`define EFP_T_BUP1_US     85.0
`define EFP_T_BUP_MIN_US  31.0
// Address fields of block selection
`define EFP_BLK_HI        15
`define EFP_BLK_LO        12
`define EFP_BLK_SEC_CODE  4'hF
// Data values
`define EFP_ERASED        8'hFF
`define EFP_NO_CODE       8'h00
`define EFP_SEC_RST       3'h0
`define EFP_CFG_RST       2'h0

`endif

// >>> design/efp_ctrl.sv
/*
 * Command execution of the dual-block flash under an external host.
 * Assumes an outside flash array: an ARR_READ on arr_out gives
 * arr_rdata_in on the next cycle; program and erase strobes are one cycle.
 */
// Overview of operation
// - Identification read returns signature or identity byte chosen by address.
// - Chip erase clears both blocks and security bits, ignoring locks.
// - Block erase picks block from A[15:12]; only unlocked blocks.
// - Sector erase of unlocked block only, lasting 1.1 to 2.3 ms.
// - Byte program only unlocked, erased byte, within 110 us.
// - Security and config bit commands take byte program time, with no array read or erased check.
// - Burst program writes every row byte, unlocked and erased only.
// - Burst first byte within 85 us, next ones 31 to 45 us.
// - Byte verify returns stored byte when block is unlocked.
// - Durations are cycle counts, so they scale inversely with clock.
`timescale 1ns/1ps
`include "efp_regs.svh"

module efp_ctrl
  import efp_pkg::*;
#(
  parameter int         T_CE_CYC   =
    $rtoi(`EFP_T_CE_MS * 1.0e6 / `EFP_CLK_NS + 0.001),
  parameter int         T_BE_CYC   =
    $rtoi(`EFP_T_BE_MS * 1.0e6 / `EFP_CLK_NS + 0.001),
  parameter int         T_SE_CYC   =
    $rtoi(`EFP_T_SE_MIN_MS * 1.0e6 / `EFP_CLK_NS + 0.999),
  parameter int         T_PB_CYC   =
    $rtoi(`EFP_T_PB_US * 1.0e3 / `EFP_CLK_NS + 0.001),
  parameter int         T_BUP1_CYC =
    $rtoi(`EFP_T_BUP1_US * 1.0e3 / `EFP_CLK_NS + 0.001),
  parameter int         T_BUP_CYC  =
    $rtoi(`EFP_T_BUP_MIN_US * 1.0e3 / `EFP_CLK_NS + 0.999),
  parameter int         ROW_BYTES  = 64,
  // Identity values, arbitrary
  parameter logic [7:0] MFR_ID     = 8'h5A,
  parameter logic [7:0] DEV_ID     = 8'hA5
) (
  input  wire logic     sys_clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     cmd_valid_in,
  input  efp_cmd_s      cmd_in,
  input  wire logic     data_valid_in,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] arr_rdata_in,
  output efp_arr_s      arr_out,
  output logic          busy_out,
  output logic          done_out,
  output logic          refused_out,
  output logic [7:0]    rdata_out,
  output logic          rdata_valid_out,
  output logic          data_ready_out,
  output logic [2:0]    sec_bits_out,
  output logic [1:0]    cfg_bits_out
);

  efp_state_s q;
  efp_state_s d;
  efp_blk_e   blk;
  logic       lock;

  function automatic efp_blk_e blk_of(input logic [15:0] a);
    if (!a[`EFP_BLK_HI]) begin
      return BLK_PRIMARY;
    end else if (a[`EFP_BLK_HI:`EFP_BLK_LO] == `EFP_BLK_SEC_CODE) begin
      return BLK_SECONDARY;
    end else begin
      return BLK_NONE;
    end
  endfunction : blk_of

  // Bit 0 locks primary, bit 1 secondary, bit 2 both
  function automatic logic locked(input efp_blk_e b, input logic [2:0] s);
    if (b == BLK_PRIMARY) begin
      return s[0] | s[2];
    end else if (b == BLK_SECONDARY) begin
      return s[1] | s[2];
    end else begin
      return 1'b1;
    end
  endfunction : locked

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.refused = 1'b0;
    d.rvalid = 1'b0;
    d.arr.op = ARR_IDLE;
    blk = blk_of(cmd_in.addr);
    lock = locked(blk, q.sec);
    case (q.st)
      ST_IDLE: begin
        if (cmd_valid_in) begin
          d.cmd = cmd_in;
          d.arr.addr = cmd_in.addr;
          d.busy = 1'b1;
          d.st = ST_WAIT;
          d.timer = 22'(T_PB_CYC - 1);
          case (cmd_in.cmd)
            CMD_READ_ID: begin
              d.rdata = cmd_in.addr[0] ? DEV_ID : MFR_ID;
              d.rvalid = 1'b1;
              d.done = 1'b1;
              d.busy = 1'b0;
              d.st = ST_IDLE;
            end
            CMD_CHIP_ERASE: begin
              d.arr.op = ARR_ERASE_CHIP;
              d.sec = `EFP_SEC_RST;
              d.timer = 22'(T_CE_CYC - 1);
            end
            CMD_BLOCK_ERASE, CMD_SECTOR_ERASE: begin
              if (lock) begin
                d.refused = 1'b1;
                d.done = 1'b1;
                d.busy = 1'b0;
                d.st = ST_IDLE;
              end else if (cmd_in.cmd == CMD_BLOCK_ERASE) begin
                d.arr.op = ARR_ERASE_BLOCK;
                d.timer = 22'(T_BE_CYC - 1);
              end else begin
                d.arr.op = ARR_ERASE_SECTOR;
                d.timer = 22'(T_SE_CYC - 1);
              end
            end
            CMD_BYTE_PROGRAM, CMD_BYTE_VERIFY: begin
              if (lock) begin
                d.refused = 1'b1;
                d.done = 1'b1;
                d.busy = 1'b0;
                d.st = ST_IDLE;
                if (cmd_in.cmd == CMD_BYTE_VERIFY) begin
                  d.rdata = `EFP_NO_CODE;
                  d.rvalid = 1'b1;
                end
              end else begin
                d.arr.op = ARR_READ;
                d.st = ST_READ;
              end
            end
            CMD_BURST_PROGRAM: begin
              if (lock) begin
                d.refused = 1'b1;
                d.done = 1'b1;
                d.busy = 1'b0;
                d.st = ST_IDLE;
              end else begin
                d.cmd.addr = cmd_in.addr & ~16'(ROW_BYTES - 1);
                d.idx = 8'h00;
                d.first = 1'b1;
                d.dready = 1'b1;
                d.st = ST_BURST;
              end
            end
            CMD_PROGRAM_SECURITY_BIT_THREE: d.sec[2] = 1'b1;
            CMD_PROGRAM_SECURITY_BIT_TWO:   d.sec[1] = 1'b1;
            CMD_PROGRAM_SECURITY_BIT_ONE:   d.sec[0] = 1'b1;
            CMD_PROGRAM_CONFIG_BIT_ONE:     d.cfg[1] = 1'b1;
            CMD_PROGRAM_CONFIG_BIT_ZERO:    d.cfg[0] = 1'b1;
            default: begin
              d.refused = 1'b1;
              d.done = 1'b1;
              d.busy = 1'b0;
              d.st = ST_IDLE;
            end
          endcase
        end
      end
      ST_READ: d.st = ST_CHECK;
      ST_CHECK: begin
        if (q.cmd.cmd == CMD_BYTE_VERIFY) begin
          d.rdata = arr_rdata_in;
          d.rvalid = 1'b1;
          d.done = 1'b1;
          d.busy = 1'b0;
          d.st = ST_IDLE;
        end else if (arr_rdata_in != `EFP_ERASED) begin
          d.refused = 1'b1;
          d.done = 1'b1;
          d.busy = 1'b0;
          d.st = ST_IDLE;
        end else begin
          d.arr.op = ARR_PROG;
          d.st = ST_WAIT;
          if (q.cmd.cmd != CMD_BURST_PROGRAM) begin
            d.timer = 22'(T_PB_CYC - 1);
          end else if (q.first) begin
            d.timer = 22'(T_BUP1_CYC - 1);
          end else begin
            d.timer = 22'(T_BUP_CYC - 1);
          end
        end
      end
      ST_WAIT: begin
        if (q.timer != 22'h000000) begin
          d.timer = q.timer - 22'h000001;
        end else if (q.cmd.cmd == CMD_BURST_PROGRAM &&
                     q.idx != 8'(ROW_BYTES - 1)) begin
          d.idx = q.idx + 8'h01;
          d.first = 1'b0;
          d.dready = 1'b1;
          d.st = ST_BURST;
        end else begin
          d.done = 1'b1;
          d.busy = 1'b0;
          d.st = ST_IDLE;
        end
      end
      ST_BURST: begin
        if (data_valid_in) begin
          d.arr.wdata = data_in;
          d.arr.addr = q.cmd.addr | 16'(q.idx);
          d.arr.op = ARR_READ;
          d.dready = 1'b0;
          d.st = ST_READ;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    if (q.st == ST_IDLE && cmd_valid_in) begin
      d.arr.wdata = cmd_in.cmd == CMD_BURST_PROGRAM ? q.arr.wdata :
                    data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{st: ST_IDLE, cmd: '{cmd: CMD_READ_ID, addr: 16'h0000},
             arr: '{op: ARR_IDLE, addr: 16'h0000, wdata: 8'h00},
             timer: 22'h000000, idx: 8'h00, first: 1'b0,
             busy: 1'b0, done: 1'b0, refused: 1'b0, rdata: 8'h00,
             rvalid: 1'b0, dready: 1'b0, sec: `EFP_SEC_RST,
             cfg: `EFP_CFG_RST};
    end else begin
      q <= d;
    end
  end

  assign arr_out         = q.arr;
  assign busy_out        = q.busy;
  assign done_out        = q.done;
  assign refused_out     = q.refused;
  assign rdata_out       = q.rdata;
  assign rdata_valid_out = q.rvalid;
  assign data_ready_out  = q.dready;
  assign sec_bits_out    = q.sec;
  assign cfg_bits_out    = q.cfg;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  id_read_a: assert property (q.st == ST_IDLE && cmd_valid_in &&
      cmd_in.cmd == CMD_READ_ID |=> rdata_valid_out && done_out &&
      rdata_out == ($past(cmd_in.addr[0]) ? DEV_ID : MFR_ID))
    else $error("identity read answer wrong");
  chip_erase_a: assert property (arr_out.op == ARR_ERASE_CHIP |->
      sec_bits_out == `EFP_SEC_RST && q.timer == 22'(T_CE_CYC - 1))
    else $error("chip erase time or security clear wrong");
  block_pick_a: assert property (arr_out.op == ARR_ERASE_BLOCK |->
      !locked(blk_of(arr_out.addr), sec_bits_out) &&
      q.timer == 22'(T_BE_CYC - 1))
    else $error("block erase on bad or locked block");
  sector_time_a: assert property (arr_out.op == ARR_ERASE_SECTOR |->
      !locked(blk_of(arr_out.addr), sec_bits_out) &&
      q.timer == 22'(T_SE_CYC - 1))
    else $error("sector erase time or lock wrong");
  prog_erased_a: assert property (arr_out.op == ARR_PROG |->
      $past(arr_rdata_in) == `EFP_ERASED &&
      !locked(blk_of(arr_out.addr), sec_bits_out))
    else $error("program of written or locked byte");
  sec_prog_a: assert property (q.st == ST_IDLE && cmd_valid_in &&
      cmd_in.cmd == CMD_PROGRAM_SECURITY_BIT_THREE |=>
      sec_bits_out[2] && busy_out && q.timer == 22'(T_PB_CYC - 1))
    else $error("security bit program wrong");
  burst_time_a: assert property (arr_out.op == ARR_PROG &&
      q.cmd.cmd == CMD_BURST_PROGRAM |-> q.timer ==
      (q.first ? 22'(T_BUP1_CYC - 1) : 22'(T_BUP_CYC - 1)))
    else $error("burst byte time wrong");
  verify_data_a: assert property (q.st == ST_CHECK &&
      q.cmd.cmd == CMD_BYTE_VERIFY |=> rdata_valid_out &&
      rdata_out == $past(arr_rdata_in) && !refused_out)
    else $error("verify data wrong");
  timer_step_a: assert property (q.st == ST_WAIT &&
      q.timer != 22'h000000 |=> q.timer == $past(q.timer) - 22'h000001)
    else $error("operation timer stalled");
  locked_verify_a: assert property (rdata_valid_out && refused_out |->
      rdata_out == `EFP_NO_CODE)
    else $error("locked verify returned code");

  cover property (arr_out.op == ARR_ERASE_CHIP);
  cover property (arr_out.op == ARR_PROG && !q.first &&
                  q.cmd.cmd == CMD_BURST_PROGRAM);
  cover property (rdata_valid_out && q.cmd.cmd == CMD_BYTE_VERIFY);
  cover property (refused_out && q.cmd.cmd == CMD_BLOCK_ERASE);

endmodule : efp_ctrl

// >>> test/efp_flash_model.sv
/* Flash array model behind the programming controller.
   Assumes one-cycle array strobes and a read answer one cycle later. */
`timescale 1ns/1ps
module efp_flash_model
  import efp_pkg::*;
#(
  parameter int SECT_LSB = 6
) (
  input  wire logic     sys_clk_in,
  input  efp_arr_s      arr_in,
  output logic [7:0]    arr_rdata_out
);
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;
  logic       rd_q   = 1'b0;
  logic       hit;
  // Outside the answer cycle the bus shows the inverse of its last value
  assign arr_rdata_out = rd_q ? last_q : ~last_q;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge sys_clk_in) begin
    rd_q <= arr_in.op == ARR_READ;
    if (arr_in.op == ARR_READ) last_q <= mem[arr_in.addr];
    if (arr_in.op == ARR_PROG) mem[arr_in.addr] = arr_in.wdata;
    if (arr_in.op >= ARR_ERASE_SECTOR && arr_in.op <= ARR_ERASE_CHIP) begin
      foreach (mem[i]) begin
        hit = arr_in.op == ARR_ERASE_CHIP;
        if (arr_in.op == ARR_ERASE_SECTOR)
          hit = i[15:SECT_LSB] == arr_in.addr[15:SECT_LSB];
        if (arr_in.op == ARR_ERASE_BLOCK)
          hit = arr_in.addr[15] ? i[15:12] == 4'hF : !i[15];
        if (hit) mem[i] = 8'hFF;
      end
    end
  end
endmodule : efp_flash_model

// >>> test/tb_efp_ctrl.sv
/* Command-level bench of the flash programming controller.
   Assumes the array model answers on the controller's array port. */
`timescale 1ns/1ps
module tb_efp_ctrl
  import efp_pkg::*;
();
  localparam int CE = 20, BE = 16, SE = 8, PB = 6, B1 = 5, BU = 3;
  logic       clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
  logic       data_valid = 1'b0;
  efp_cmd_s   cmd = '0;
  logic [7:0] data = 8'h00, arr_rdata, rdata;
  efp_arr_s   arr;
  logic       busy, done, refused, rdata_valid, data_ready;
  logic [2:0] sec;
  logic [1:0] cfg;
  int         fails = 0, checked = 0;

  always #2.5 clk = ~clk;

  efp_ctrl #(.T_CE_CYC(CE), .T_BE_CYC(BE), .T_SE_CYC(SE), .T_PB_CYC(PB),
    .T_BUP1_CYC(B1), .T_BUP_CYC(BU), .ROW_BYTES(4)) i_efp_ctrl (
    .sys_clk_in(clk), .rst_n_in(rst_n), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .data_valid_in(data_valid), .data_in(data),
    .arr_rdata_in(arr_rdata), .arr_out(arr), .busy_out(busy),
    .done_out(done), .refused_out(refused), .rdata_out(rdata),
    .rdata_valid_out(rdata_valid), .data_ready_out(data_ready),
    .sec_bits_out(sec), .cfg_bits_out(cfg));

  efp_flash_model i_efp_flash_model (.sys_clk_in(clk), .arr_in(arr),
    .arr_rdata_out(arr_rdata));

  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk

  // Drive at a falling edge; taken at the next rising edge
  task automatic issue(input efp_cmd_e c, input logic [15:0] a,
                       input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd = '{cmd: c, addr: a};
    data = d;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : issue

  task automatic fin(input int lat, input logic rf);
    int n;
    for (n = 1; n <= 200; n++) begin
      if (done === 1'b1) break;
      @(negedge clk);
    end
    if (n > 200) begin
      fails++;
      tally_and_finish();
    end
    if (lat >= 0) chk(8'(n), 8'(lat));
    chk({7'h0, refused}, {7'h0, rf});
  endtask : fin

  task automatic run(input efp_cmd_e c, input logic [15:0] a,
                     input logic [7:0] d, input int lat, input logic rf);
    issue(c, a, d);
    if (lat != 1) chk({7'h0, busy}, 8'h01);
    fin(lat, rf);
  endtask : run

  task automatic vfy(input logic [15:0] a, input logic [7:0] e,
                     input logic rf);
    run(CMD_BYTE_VERIFY, a, 8'h00, rf ? 1 : 3, rf);
    chk({7'h0, rdata_valid}, 8'h01);
    chk(rdata, e);
  endtask : vfy

  task automatic burst(input logic [15:0] a);
    int g[3];
    int k, n;
    issue(CMD_BURST_PROGRAM, a, 8'h00);
    for (k = 0; k < 4; k++) begin
      for (n = 0; n < 200 && data_ready !== 1'b1; n++) @(negedge clk);
      if (n >= 200) begin
        fails++;
        tally_and_finish();
      end
      if (k > 0) g[k-1] = n;
      data_valid = 1'b1;
      data = 8'hA0 + 8'(k);
      @(negedge clk);
      data_valid = 1'b0;
    end
    fin(-1, 1'b0);
    chk(8'(g[0] - g[1]), 8'(B1 - BU));
    chk(8'(g[1]), 8'(g[2]));
  endtask : burst

  initial begin
    repeat (12) @(negedge clk);
    chk({busy, done, sec, cfg}, 8'h00);
    rst_n = 1'b1;
    run(CMD_READ_ID, 16'h0000, 8'h00, 1, 1'b0);
    chk(rdata, 8'h5A);
    run(CMD_READ_ID, 16'h0001, 8'h00, 1, 1'b0);
    chk(rdata, 8'hA5);
    run(CMD_BYTE_PROGRAM, 16'h0010, 8'h3C, 3 + PB, 1'b0);
    run(CMD_BYTE_PROGRAM, 16'h0010, 8'h11, 3, 1'b1);
    vfy(16'h0010, 8'h3C, 1'b0);
    run(CMD_BYTE_PROGRAM, 16'hF005, 8'h77, 3 + PB, 1'b0);
    run(CMD_SECTOR_ERASE, 16'h0000, 8'h00, 1 + SE, 1'b0);
    vfy(16'h0010, 8'hFF, 1'b0);
    vfy(16'hF005, 8'h77, 1'b0);
    burst(16'h0102);
    vfy(16'h0100, 8'hA0, 1'b0);
    vfy(16'h0103, 8'hA3, 1'b0);
    run(CMD_BLOCK_ERASE, 16'h8000, 8'h00, 1, 1'b1);
    run(CMD_BLOCK_ERASE, 16'h0000, 8'h00, 1 + BE, 1'b0);
    vfy(16'h0103, 8'hFF, 1'b0);
    vfy(16'hF005, 8'h77, 1'b0);
    run(CMD_BLOCK_ERASE, 16'hF000, 8'h00, 1 + BE, 1'b0);
    vfy(16'hF005, 8'hFF, 1'b0);
    run(CMD_PROGRAM_CONFIG_BIT_ZERO, 16'h0, 8'h0, 1 + PB, 1'b0);
    chk({6'h0, cfg}, 8'h01);
    run(CMD_PROGRAM_CONFIG_BIT_ONE, 16'h0, 8'h0, 1 + PB, 1'b0);
    chk({6'h0, cfg}, 8'h03);
    run(CMD_BYTE_PROGRAM, 16'hF006, 8'h55, 3 + PB, 1'b0);
    run(CMD_BYTE_PROGRAM, 16'h0020, 8'h66, 3 + PB, 1'b0);
    run(CMD_PROGRAM_SECURITY_BIT_ONE, 16'h0, 8'h0, 1 + PB, 1'b0);
    chk({5'h0, sec}, 8'h01);
    run(CMD_BYTE_PROGRAM, 16'h0030, 8'h12, 1, 1'b1);
    vfy(16'h0020, 8'h00, 1'b1);
    run(CMD_SECTOR_ERASE, 16'h0000, 8'h00, 1, 1'b1);
    run(CMD_BLOCK_ERASE, 16'h0000, 8'h00, 1, 1'b1);
    vfy(16'hF006, 8'h55, 1'b0);
    run(CMD_PROGRAM_SECURITY_BIT_TWO, 16'h0, 8'h0, 1 + PB, 1'b0);
    chk({5'h0, sec}, 8'h03);
    vfy(16'hF006, 8'h00, 1'b1);
    run(CMD_PROGRAM_SECURITY_BIT_THREE, 16'h0, 8'h0, 1 + PB, 1'b0);
    chk({5'h0, sec}, 8'h07);
    run(CMD_CHIP_ERASE, 16'h0000, 8'h00, 1 + CE, 1'b0);
    chk({3'h0, sec, cfg}, 8'h03);
    vfy(16'h0020, 8'hFF, 1'b0);
    vfy(16'hF006, 8'hFF, 1'b0);
    tally_and_finish();
  end
endmodule : tb_efp_ctrl
